// ---- pkg/irq_cfg_pkg.sv ----
`default_nettype none
package irq_cfg_pkg;
	// Register addresses on the control port
	localparam logic [7:0] ADDR_IRQ_CONFIG = 8'h32;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h33;
	localparam logic [7:0] ADDR_IRQ_LATCHED = 8'h36;
	localparam logic [7:0] ADDR_MIC_BIAS = 8'h3B;
	localparam logic [7:0] ADDR_CHAN1_VOLUME = 8'h3E;
	localparam logic [7:0] ADDR_CHAN1_GAIN = 8'h3F;
	localparam logic [7:0] ADDR_CHAN1_PHASE = 8'h40;
	localparam logic [7:0] ADDR_CHAN2_SOURCE = 8'h41;
	// Reset values
	localparam logic [7:0] RST_IRQ_CONFIG = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
	localparam logic [7:0] RST_LATCHED = 8'h00;
	localparam logic [7:0] RST_MIC_BIAS = 8'h00;
	localparam logic [7:0] RST_CHAN1_VOLUME = 8'hC9;
	localparam logic [7:0] RST_CHAN1_GAIN = 8'h80;
	localparam logic [7:0] RST_CHAN1_PHASE = 8'h00;
	localparam logic [7:0] RST_CHAN2_SOURCE = 8'h00;
	// Writable bits per register
	localparam logic [7:0] WMASK_IRQ_CONFIG = 8'hE4;
	localparam logic [7:0] WMASK_MIC_BIAS = 8'h73;
	localparam logic [7:0] WMASK_CHAN1_GAIN = 8'hF0;
	localparam logic [7:0] WMASK_CHAN2_SOURCE = 8'hFD;
	localparam logic [7:0] WMASK_SOURCES = 8'hF8;
	// Field positions
	localparam int POS_IRQ_POLARITY = 7;
	localparam int POS_EVENT_HI = 6;
	localparam int POS_EVENT_LO = 5;
	localparam int POS_READBACK = 2;
	localparam int POS_BIAS_HI = 6;
	localparam int POS_BIAS_LO = 4;
	localparam int POS_GAIN_HI = 7;
	localparam int POS_GAIN_LO = 4;
	localparam int POS_SRC_HI = 6;
	localparam int POS_SRC_LO = 5;
	// Source bit positions in mask and latched status
	localparam int POS_SRC_CLOCK_ERR = 7;
	localparam int POS_SRC_PLL_LOCK = 6;
	localparam int POS_SRC_SATURATION = 5;
	localparam int POS_SRC_VAD_UP = 4;
	localparam int POS_SRC_VAD_DOWN = 3;
	localparam int NUM_SOURCES = 5;
	// Event style encodings
	localparam logic [1:0] EVENT_LEVEL = 2'h0;
	localparam logic [1:0] EVENT_RESERVED = 2'h1;
	localparam logic [1:0] EVENT_REPEAT = 2'h2;
	localparam logic [1:0] EVENT_ONCE = 2'h3;
	// Bias codes
	localparam logic [2:0] BIAS_REF = 3'h0;
	localparam logic [2:0] BIAS_REF_X1096 = 3'h1;
	localparam logic [2:0] BIAS_SUPPLY = 3'h6;
	localparam logic [2:0] BIAS_GPI = 3'h7;
	// Channel 2 source codes
	localparam logic [1:0] SRC_DISABLED = 2'h0;
	localparam logic [1:0] SRC_PDM = 2'h2;
	// Volume and gain anchors, in tenths of a dB
	localparam logic [7:0] VOL_MUTE_CODE = 8'h00;
	localparam logic [7:0] VOL_ZERO_DB_CODE = 8'hC9;
	localparam int VOL_STEP_TENTHS = 5;
	localparam logic [3:0] GAIN_ZERO_DB_CODE = 4'h8;
	localparam int GAIN_STEP_TENTHS = 1;
	// Multipurpose pin function code for the interrupt
	localparam logic [3:0] PIN_FUNC_IRQ = 4'h2;
	// Interrupt pulse timing
	localparam int CLK_HZ = 100_000_000;
	localparam int PULSE_MS = 2;
	localparam int PERIOD_MS = 4;
	localparam int PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);
	localparam int PERIOD_CYCLES = PERIOD_MS * (CLK_HZ / 1000);

	typedef struct packed {
		logic write_strobe;
		logic read_strobe;
		logic [7:0] address;
		logic [7:0] write_data;
	} reg_access_t;

	typedef struct packed {
		logic [7:0] chan1_volume_code;
		logic signed [11:0] chan1_volume_tenths_db;
		logic chan1_muted;
		logic [3:0] chan1_gain_trim_code;
		logic signed [4:0] chan1_gain_tenths_db;
		logic [7:0] chan1_phase_trim_code;
		logic [2:0] bias_level_select;
		logic bias_pin_is_input;
		logic [1:0] chan2_source_select;
		logic chan2_pdm_enable;
	} channel_cfg_t;
endpackage
`default_nettype wire

// ---- core/irq_pulse_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Pulse shaper for the repeating and one-shot interrupt event styles
module irq_pulse_timer #(
	parameter int PULSE_CYCLES = irq_cfg_pkg::PULSE_CYCLES,
	parameter int PERIOD_CYCLES = irq_cfg_pkg::PERIOD_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [1:0] event_style,
	input wire logic pending,
	input wire logic new_event,
	output logic irq_active
);
	logic [31:0] count;
	logic running;
	wire logic repeat_mode = (event_style == irq_cfg_pkg::EVENT_REPEAT);
	wire logic once_mode = (event_style == irq_cfg_pkg::EVENT_ONCE);
	wire logic last = (count == 32'(PERIOD_CYCLES - 1));
	wire logic once_done = (count == 32'(PULSE_CYCLES - 1));
	wire logic start = (repeat_mode && pending) || (once_mode && new_event);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			count <= 32'h0;
			running <= 1'b0;
		end else if (!running) begin
			running <= start;
			count <= 32'h0;
		end else if (repeat_mode) begin
			// Next period starts only while something stays pending
			running <= !(last && !pending);
			count <= last ? 32'h0 : count + 32'h1;
		end else if (once_mode) begin
			// A fresh event restarts the pulse
			running <= !once_done || new_event;
			count <= (once_done || new_event) ? 32'h0 : count + 32'h1;
		end else begin
			running <= 1'b0;
			count <= 32'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_active <= 1'b0;
		end else if (repeat_mode) begin
			irq_active <= (running && !last && count < 32'(PULSE_CYCLES - 1)) || (!running && pending)
				|| (running && last && pending);
		end else if (once_mode) begin
			irq_active <= (running && !once_done) || new_event;
		end else begin
			irq_active <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- core/irq_and_channel_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_and_channel_config_regs #(
	parameter int PULSE_CYCLES = irq_cfg_pkg::PULSE_CYCLES,
	parameter int PERIOD_CYCLES = irq_cfg_pkg::PERIOD_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire irq_cfg_pkg::reg_access_t access,
	output logic [7:0] read_data,
	input wire logic [irq_cfg_pkg::NUM_SOURCES-1:0] source_events,
	input wire logic [3:0] multipurpose_pin_function,
	input wire logic mic_bias_pin_in,
	output logic second_general_input,
	output logic irq_pin_out,
	output logic irq_pin_oe,
	output irq_cfg_pkg::channel_cfg_t channel_cfg
);
	////////////////////////////////////////////////////////////////
	logic [7:0] irq_config;
	logic [7:0] interrupt_source_mask;
	logic [7:0] interrupt_latched_status;
	logic [7:0] mic_bias_config;
	logic [7:0] chan1_volume;
	logic [7:0] chan1_gain_trim;
	logic [7:0] chan1_phase_trim;
	logic [7:0] chan2_source_config;
	logic irq_shaped;

	function automatic logic hit(input irq_cfg_pkg::reg_access_t a, input logic [7:0] addr);
		hit = a.write_strobe && (a.address == addr);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] wmask);
		merge = (new_v & wmask) | (old_v & ~wmask);
	endfunction

	////////////////////////////////////////////////////////////////
	// Decode
	wire logic irq_polarity = irq_config[irq_cfg_pkg::POS_IRQ_POLARITY];
	wire logic [1:0] event_style = irq_config[irq_cfg_pkg::POS_EVENT_HI:irq_cfg_pkg::POS_EVENT_LO];
	wire logic latch_readback_filter = irq_config[irq_cfg_pkg::POS_READBACK];
	wire logic [7:0] irq_mask_bits = interrupt_source_mask;
	wire logic [7:0] irq_latched_flags = interrupt_latched_status;
	// Map the five sources to bits 7..3
	wire logic [7:0] event_vector = {source_events, 3'h0};
	wire logic [7:0] unmasked_latched = irq_latched_flags & ~irq_mask_bits & irq_cfg_pkg::WMASK_SOURCES;
	wire logic [7:0] unmasked_events = event_vector & ~irq_mask_bits & irq_cfg_pkg::WMASK_SOURCES;
	wire logic any_pending = |unmasked_latched;
	wire logic any_new_event = |unmasked_events;
	wire logic [7:0] latched_view = latch_readback_filter ? unmasked_latched : irq_latched_flags;
	wire logic read_latched = access.read_strobe && (access.address == irq_cfg_pkg::ADDR_IRQ_LATCHED);
	wire logic level_active = (event_style == irq_cfg_pkg::EVENT_LEVEL) && any_pending;
	wire logic irq_asserted = level_active || irq_shaped;
	wire logic pin_is_irq = (multipurpose_pin_function == irq_cfg_pkg::PIN_FUNC_IRQ);
	wire logic [2:0] bias_level_select = mic_bias_config[irq_cfg_pkg::POS_BIAS_HI:irq_cfg_pkg::POS_BIAS_LO];
	wire logic [3:0] gain_code = chan1_gain_trim[irq_cfg_pkg::POS_GAIN_HI:irq_cfg_pkg::POS_GAIN_LO];
	wire logic [1:0] chan2_source_select = chan2_source_config[irq_cfg_pkg::POS_SRC_HI:irq_cfg_pkg::POS_SRC_LO];

	logic [7:0] next_read_data;
	always_comb begin
		case (access.address)
			irq_cfg_pkg::ADDR_IRQ_CONFIG: next_read_data = irq_config;
			irq_cfg_pkg::ADDR_IRQ_MASK: next_read_data = interrupt_source_mask;
			irq_cfg_pkg::ADDR_IRQ_LATCHED: next_read_data = latched_view;
			irq_cfg_pkg::ADDR_MIC_BIAS: next_read_data = mic_bias_config;
			irq_cfg_pkg::ADDR_CHAN1_VOLUME: next_read_data = chan1_volume;
			irq_cfg_pkg::ADDR_CHAN1_GAIN: next_read_data = chan1_gain_trim;
			irq_cfg_pkg::ADDR_CHAN1_PHASE: next_read_data = chan1_phase_trim;
			irq_cfg_pkg::ADDR_CHAN2_SOURCE: next_read_data = chan2_source_config;
			default: next_read_data = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_config <= irq_cfg_pkg::RST_IRQ_CONFIG;
			interrupt_source_mask <= irq_cfg_pkg::RST_IRQ_MASK;
			mic_bias_config <= irq_cfg_pkg::RST_MIC_BIAS;
			chan1_volume <= irq_cfg_pkg::RST_CHAN1_VOLUME;
			chan1_gain_trim <= irq_cfg_pkg::RST_CHAN1_GAIN;
			chan1_phase_trim <= irq_cfg_pkg::RST_CHAN1_PHASE;
			chan2_source_config <= irq_cfg_pkg::RST_CHAN2_SOURCE;
		end else begin
			// reserved read-only bits keep reset value
			if (hit(access, irq_cfg_pkg::ADDR_IRQ_CONFIG)) begin
				irq_config <= merge(irq_config, access.write_data, irq_cfg_pkg::WMASK_IRQ_CONFIG);
			end
			if (hit(access, irq_cfg_pkg::ADDR_IRQ_MASK)) begin
				interrupt_source_mask <= access.write_data;
			end
			if (hit(access, irq_cfg_pkg::ADDR_MIC_BIAS)) begin
				mic_bias_config <= merge(mic_bias_config, access.write_data, irq_cfg_pkg::WMASK_MIC_BIAS);
			end
			if (hit(access, irq_cfg_pkg::ADDR_CHAN1_VOLUME)) begin
				chan1_volume <= access.write_data;
			end
			if (hit(access, irq_cfg_pkg::ADDR_CHAN1_GAIN)) begin
				chan1_gain_trim <= merge(chan1_gain_trim, access.write_data, irq_cfg_pkg::WMASK_CHAN1_GAIN);
			end
			if (hit(access, irq_cfg_pkg::ADDR_CHAN1_PHASE)) begin
				chan1_phase_trim <= access.write_data;
			end
			if (hit(access, irq_cfg_pkg::ADDR_CHAN2_SOURCE)) begin
				chan2_source_config <= merge(chan2_source_config, access.write_data,
					irq_cfg_pkg::WMASK_CHAN2_SOURCE);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Latched flags, one per bit; the reserved low bits have no event and stay clear
	genvar i;
	generate
		for (i = 0; i <= irq_cfg_pkg::POS_SRC_CLOCK_ERR; i++) begin : g_flag
			always_ff @(posedge core_clk) begin
				if (reset) begin
					interrupt_latched_status[i] <= irq_cfg_pkg::RST_LATCHED[i];
				end else if (event_vector[i]) begin
					interrupt_latched_status[i] <= 1'b1;
				end else if (read_latched) begin
					interrupt_latched_status[i] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// repeating and one-shot pulse styles
	irq_pulse_timer #(
		.PULSE_CYCLES(PULSE_CYCLES),
		.PERIOD_CYCLES(PERIOD_CYCLES)
	) u_pulse (
		.core_clk(core_clk),
		.reset(reset),
		.event_style(event_style),
		.pending(any_pending),
		.new_event(any_new_event),
		.irq_active(irq_shaped)
	);

	////////////////////////////////////////////////////////////////
	// Outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			read_data <= 8'h00;
			irq_pin_out <= 1'b1;
			irq_pin_oe <= 1'b0;
			second_general_input <= 1'b0;
			channel_cfg <= '0;
		end else begin
			read_data <= next_read_data;
			irq_pin_out <= irq_polarity ? irq_asserted : !irq_asserted;
			irq_pin_oe <= pin_is_irq;
			second_general_input <= (bias_level_select == irq_cfg_pkg::BIAS_GPI) ? mic_bias_pin_in : 1'b0;
			channel_cfg.bias_level_select <= bias_level_select;
			channel_cfg.bias_pin_is_input <= (bias_level_select == irq_cfg_pkg::BIAS_GPI);
			channel_cfg.chan1_volume_code <= chan1_volume;
			channel_cfg.chan1_muted <= (chan1_volume == irq_cfg_pkg::VOL_MUTE_CODE);
			channel_cfg.chan1_volume_tenths_db <= 12'(($signed({4'h0, chan1_volume})
				- $signed({4'h0, irq_cfg_pkg::VOL_ZERO_DB_CODE})) * irq_cfg_pkg::VOL_STEP_TENTHS);
			channel_cfg.chan1_gain_trim_code <= gain_code;
			channel_cfg.chan1_gain_tenths_db <= 5'(($signed({1'b0, gain_code})
				- $signed({1'b0, irq_cfg_pkg::GAIN_ZERO_DB_CODE})) * irq_cfg_pkg::GAIN_STEP_TENTHS);
			channel_cfg.chan1_phase_trim_code <= chan1_phase_trim;
			channel_cfg.chan2_source_select <= chan2_source_select;
			channel_cfg.chan2_pdm_enable <= (chan2_source_select == irq_cfg_pkg::SRC_PDM);
		end
	end
endmodule
`default_nettype wire

// ---- dv/irq_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
	input wire logic core_clk,
	input wire logic [7:0] read_data,
	output logic [17:0] access
);
	initial access = '0;
	// callers pass reserved bits at reset values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) access <= {1'b1, 1'b0, a, d};
		@(posedge core_clk) access[17] <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk) access <= {1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk) access[16] <= 1'b0;
		#1 d = read_data;
	endtask
endmodule
`default_nettype wire

// ---- dv/irq_and_channel_config_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_and_channel_config_regs_props #(
	parameter int PULSE_CYCLES = 4,
	parameter int PERIOD_CYCLES = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire irq_cfg_pkg::reg_access_t access,
	input wire logic [7:0] read_data,
	input wire logic [irq_cfg_pkg::NUM_SOURCES-1:0] source_events,
	input wire logic [3:0] multipurpose_pin_function,
	input wire logic mic_bias_pin_in,
	input wire logic second_general_input,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe,
	input wire irq_cfg_pkg::channel_cfg_t channel_cfg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_pin_enable: assert property (
		!$past(reset) |-> irq_pin_oe == ($past(multipurpose_pin_function) == irq_cfg_pkg::PIN_FUNC_IRQ))
		else $error("pin enable does not follow function code");
	a_cfg_reset: assert property ($fell(reset) |=> channel_cfg.chan1_volume_code == 8'hC9 &&
		channel_cfg.chan1_gain_trim_code == 4'h8 && channel_cfg.chan1_phase_trim_code == 8'h00)
		else $error("channel settings wrong after reset");
	a_volume_decode: assert property (!$past(reset) |->
		int'(channel_cfg.chan1_volume_tenths_db) == (int'(channel_cfg.chan1_volume_code) - 201) * 5 &&
		channel_cfg.chan1_muted == (channel_cfg.chan1_volume_code == 8'h00))
		else $error("volume decode wrong");
	a_gain_decode: assert property (!$past(reset) |->
		int'(channel_cfg.chan1_gain_tenths_db) == int'(channel_cfg.chan1_gain_trim_code) - 8)
		else $error("gain decode wrong");
	a_bias_input: assert property (
		channel_cfg.bias_pin_is_input == (channel_cfg.bias_level_select == 3'h7))
		else $error("bias input decode wrong");
	a_chan2_pdm: assert property (
		channel_cfg.chan2_pdm_enable == (channel_cfg.chan2_source_select == 2'h2))
		else $error("channel 2 source decode wrong");
	a_flag_clear: assert property (
		access.read_strobe && access.address == 8'h36 && source_events == '0 ##1
		access.address == 8'h36 && source_events == '0 |=> read_data[7:3] == 5'h00)
		else $error("flags not cleared by status read");
	a_status_low: assert property (
		!$past(reset) && $past(access.address) == 8'h36 |-> read_data[2:0] == 3'h0)
		else $error("status reserved bits not zero");
endmodule
bind irq_and_channel_config_regs irq_and_channel_config_regs_props #(
	.PULSE_CYCLES(PULSE_CYCLES),
	.PERIOD_CYCLES(PERIOD_CYCLES)
) i_irq_and_channel_config_regs_props (.core_clk(core_clk), .reset(reset), .access(access),
	.read_data(read_data), .source_events(source_events), .multipurpose_pin_function(multipurpose_pin_function),
	.mic_bias_pin_in(mic_bias_pin_in), .second_general_input(second_general_input),
	.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .channel_cfg(channel_cfg));
`default_nettype wire

// ---- dv/test_irq_and_channel_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_irq_and_channel_config_regs;
	localparam int PULSE = 4;
	localparam int PERIOD = 8;
	logic core_clk;
	logic reset;
	logic [4:0] source_events;
	logic [3:0] multipurpose_pin_function;
	logic mic_bias_pin_in;
	logic [7:0] read_data;
	logic second_general_input;
	logic irq_pin_out;
	logic irq_pin_oe;
	irq_cfg_pkg::reg_access_t access;
	irq_cfg_pkg::channel_cfg_t channel_cfg;
	int fail_count;
	int cmp_count;
	logic [7:0] rv;

	irq_host_model i_irq_host_model (.core_clk(core_clk), .read_data(read_data), .access(access));
	irq_and_channel_config_regs #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) i_irq_and_channel_config_regs (
		.core_clk(core_clk), .reset(reset), .access(access), .read_data(read_data),
		.source_events(source_events), .multipurpose_pin_function(multipurpose_pin_function),
		.mic_bias_pin_in(mic_bias_pin_in), .second_general_input(second_general_input),
		.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .channel_cfg(channel_cfg));

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_irq_host_model.rd(a, d);
		chk($sformatf("register %h", a), e, d);
	endtask
	task automatic fire(input logic [4:0] ev);
		@(posedge core_clk) source_events <= ev;
		@(posedge core_clk) source_events <= 5'h00;
	endtask
	task automatic t_reset_values;
		logic [7:0] a[9] = '{8'h32, 8'h33, 8'h36, 8'h3B, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h34};
		logic [7:0] e[9] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hC9, 8'h80, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++)
			rchk(a[i], e[i]);
	endtask
	task automatic t_latch;
		fire(5'h11);
		repeat (3) @(posedge core_clk);
		#1 chk("irq_pin_out", 1, irq_pin_out);
		chk("irq_pin_oe", 1, irq_pin_oe);
		rchk(8'h36, 8'h88);
		rchk(8'h36, 8'h00);
		i_irq_host_model.wr(8'h33, 8'h87);
		i_irq_host_model.wr(8'h32, 8'h04);
		fire(5'h11);
		repeat (3) @(posedge core_clk);
		#1 chk("irq_pin_out", 0, irq_pin_out);
		rchk(8'h36, 8'h08);
		repeat (3) @(posedge core_clk);
		#1 chk("irq_pin_out", 1, irq_pin_out);
		@(posedge core_clk) multipurpose_pin_function <= 4'h4;
		repeat (2) @(posedge core_clk);
		#1 chk("irq_pin_oe", 0, irq_pin_oe);
		@(posedge core_clk) multipurpose_pin_function <= 4'h2;
	endtask
	task automatic t_cfg;
		i_irq_host_model.wr(8'h3E, 8'h00);
		i_irq_host_model.wr(8'h3F, 8'hF0);
		// microphone pin routing lies outside this block
		i_irq_host_model.wr(8'h41, 8'h40);
		i_irq_host_model.wr(8'h3B, 8'h70);
		repeat (3) @(posedge core_clk);
		#1 chk("chan1_muted", 1, channel_cfg.chan1_muted);
		chk("gain_tenths", 7, channel_cfg.chan1_gain_tenths_db);
		chk("chan2_pdm_enable", 1, channel_cfg.chan2_pdm_enable);
		chk("second_general_input", 1, second_general_input);
		chk("bias_pin_is_input", 1, channel_cfg.bias_pin_is_input);
		chk("chan2_source_select", 2, channel_cfg.chan2_source_select);
		chk("gain_trim_code", 16'h000F, channel_cfg.chan1_gain_trim_code);
		@(posedge core_clk) mic_bias_pin_in <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk("second_general_input", 0, second_general_input);
		@(posedge core_clk) mic_bias_pin_in <= 1'b1;
		i_irq_host_model.wr(8'h3E, 8'hFF);
		i_irq_host_model.wr(8'h3B, 8'h00);
		i_irq_host_model.wr(8'h40, 8'hFF);
		rchk(8'h40, 8'hFF);
		chk("volume_tenths", 16'(270), channel_cfg.chan1_volume_tenths_db);
		chk("second_general_input", 0, second_general_input);
		chk("phase_trim_code", 16'h00FF, channel_cfg.chan1_phase_trim_code);
		chk("bias_level_select", 0, channel_cfg.bias_level_select);
		chk("chan1_volume_code", 16'h00FF, channel_cfg.chan1_volume_code);
	endtask
	task automatic t_styles;
		int n;
		int e[4] = '{2 * PERIOD, 0, 2 * PULSE, PULSE};
		for (int s = 0; s < 4; s++) begin
			i_irq_host_model.wr(8'h32, 8'h80 | 8'(s << 5));
			fire(5'h08);
			for (int w = 0; w < 4 && irq_pin_out !== 1'b1; w++)
				@(negedge core_clk);
			n = int'(irq_pin_out === 1'b1);
			repeat (2 * PERIOD - 1) begin
				@(negedge core_clk);
				n += int'(irq_pin_out === 1'b1);
			end
			chk("irq_high_cycles", 16'(e[s]), 16'(n));
			i_irq_host_model.rd(8'h36, rv);
			repeat (PERIOD) @(posedge core_clk);
			#1 chk("irq_after_clear", 0, irq_pin_out);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		reset = 1'b1;
		source_events = 5'h00;
		multipurpose_pin_function = 4'h2;
		mic_bias_pin_in = 1'b1;
		fail_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		t_reset_values;
		t_latch;
		t_cfg;
		t_styles;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		test_done;
	end
endmodule
`default_nettype wire
